// [hdl/ctf_top.v]
// Purpose: charge threshold flags with AXI4-Lite registers
// Assumes: single clock, synchronous active-low reset
// Notes: flags are read-only; thresholds and load model writable
//
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "ctf_map.vh"
module ctf_top #(
	parameter W = 16
) (
	input wire aclk,
	input wire aresetn,
	input wire cap_valid,
	input wire [W-1:0] remaining_charge,
	input wire volt_valid,
	input wire [W-1:0] cell_voltage,
	output wire low_capacity_flag,
	output wire shutdown_warning_flag,
	output wire load_model_status_bit,
	output wire charge_level_int,
	input wire [`CTF_ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`CTF_ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready
);
	reg [W-1:0] cap_warn_reg;
	reg [W-1:0] sd_set_reg;
	reg [W-1:0] sd_clr_reg;
	reg load_model_reg;
	reg low_cap_reg;
	reg sd_reg;
	reg int_reg;
	wire low_cap_next;
	wire sd_next;
	reg aw_got_reg;
	reg w_got_reg;
	reg [`CTF_ADDR_W-1:0] awaddr_reg;
	reg [31:0] wdata_reg;
	reg [3:0] wstrb_reg;
	reg bvalid_reg;
	reg [1:0] bresp_reg;
	reg rvalid_reg;
	reg [1:0] rresp_reg;
	reg [31:0] rdata_reg;
	wire do_write;

	// merge byte lanes into a 16-bit field
	function [W-1:0] merge;
		input [W-1:0] old;
		input [31:0] d;
		input [3:0] s;
		begin
			merge = old;
			if (s[0])
				merge[7:0] = d[7:0];
			if (s[1])
				merge[15:8] = d[15:8];
		end
	endfunction

	// decode of a mapped offset
	function mapped;
		input [`CTF_ADDR_W-1:0] a;
		begin
			mapped = (a == `CTF_OFF_FLAGS) || (a == `CTF_OFF_CAP_WARN)
				|| (a == `CTF_OFF_SD_SET) || (a == `CTF_OFF_SD_CLR);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	ctf_compare #(
		.W(W)
	) u_cmp (
		.cap_valid(cap_valid),
		.cap(remaining_charge),
		.volt_valid(volt_valid),
		.volt(cell_voltage),
		.cap_warn(cap_warn_reg),
		.sd_set(sd_set_reg),
		.sd_clr(sd_clr_reg),
		.low_cap_cur(low_cap_reg),
		.sd_cur(sd_reg),
		.low_cap_next(low_cap_next),
		.sd_next(sd_next)
	);

	// flags and change interrupt
	always @(posedge aclk) begin
		if (!aresetn) begin
			low_cap_reg <= 1'b0;
			sd_reg <= 1'b0;
			int_reg <= 1'b0;
		end else begin
			low_cap_reg <= low_cap_next; // see RULE1
			sd_reg <= sd_next; // see RULE3
			int_reg <= (sd_next != sd_reg); // see RULE5
		end
	end

	assign low_capacity_flag = low_cap_reg;
	assign shutdown_warning_flag = sd_reg;
	assign charge_level_int = int_reg;
	assign load_model_status_bit = load_model_reg; // see RULE7

	////////////////////////////////////////////////////////////////////////
	// write channel: address and data in either order
	assign s_axi_awready = !aw_got_reg && !bvalid_reg;
	assign s_axi_wready = !w_got_reg && !bvalid_reg;
	assign do_write = aw_got_reg && w_got_reg && !bvalid_reg;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			awaddr_reg <= {`CTF_ADDR_W{1'b0}};
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `CTF_RESP_OKAY;
			cap_warn_reg <= `CTF_RST_CAP_WARN;
			sd_set_reg <= `CTF_RST_SD_SET;
			sd_clr_reg <= `CTF_RST_SD_CLR;
			load_model_reg <= `CTF_RST_LOAD_MODEL; // see RULE6
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= mapped(awaddr_reg) ? `CTF_RESP_OKAY : `CTF_RESP_SLVERR;
				case (awaddr_reg)
				`CTF_OFF_FLAGS: begin
					// only the load model bit is writable here
					if (wstrb_reg[0])
						load_model_reg <= wdata_reg[`CTF_BIT_LOAD_MODEL]; // see RULE6
				end
				`CTF_OFF_CAP_WARN: cap_warn_reg <= merge(cap_warn_reg, wdata_reg, wstrb_reg);
				`CTF_OFF_SD_SET: sd_set_reg <= merge(sd_set_reg, wdata_reg, wstrb_reg);
				`CTF_OFF_SD_CLR: sd_clr_reg <= merge(sd_clr_reg, wdata_reg, wstrb_reg);
				default: begin
				end
				endcase
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;

	////////////////////////////////////////////////////////////////////////
	// read channel, one outstanding read
	assign s_axi_arready = !rvalid_reg;

	always @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rresp_reg <= `CTF_RESP_OKAY;
			rdata_reg <= 32'h00000000;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				rvalid_reg <= 1'b1;
				rresp_reg <= mapped(s_axi_araddr) ? `CTF_RESP_OKAY : `CTF_RESP_SLVERR;
				rdata_reg <= 32'h00000000;
				case (s_axi_araddr)
				`CTF_OFF_FLAGS: begin
					rdata_reg[`CTF_BIT_LOW_CAP] <= low_cap_reg;
					rdata_reg[`CTF_BIT_SHUTDOWN] <= sd_reg;
					rdata_reg[`CTF_BIT_LOAD_MODEL] <= load_model_reg; // see RULE7
				end
				`CTF_OFF_CAP_WARN: rdata_reg[W-1:0] <= cap_warn_reg;
				`CTF_OFF_SD_SET: rdata_reg[W-1:0] <= sd_set_reg;
				`CTF_OFF_SD_CLR: rdata_reg[W-1:0] <= sd_clr_reg;
				default: begin
				end
				endcase
			end else if (rvalid_reg && s_axi_rready) begin
				rvalid_reg <= 1'b0;
			end
		end
	end

	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;
endmodule

// [hdl/ctf_map.vh]
// Purpose: constants for the charge threshold flags block
// Assumes: AXI4-Lite register access, 32-bit data
// Notes: byte offsets are word aligned
// Functional notes
// RULE1 - set low-capacity flag below capacity warn level
// RULE2 - clear low-capacity flag above same level
// RULE3 - set shutdown flag below shutdown set voltage
// RULE4 - clear shutdown flag when set, above clear voltage
// RULE5 - pulse interrupt on every shutdown flag change
// RULE6 - load model 0 constant current, 1 power
// RULE7 - status bit mirrors stored load model
// RULE8 - compare on each new sample, same cycle
`ifndef CTF_MAP_VH
`define CTF_MAP_VH
`define CTF_ADDR_W 4
`define CTF_OFF_FLAGS 4'h0
`define CTF_OFF_CAP_WARN 4'h4
`define CTF_OFF_SD_SET 4'h8
`define CTF_OFF_SD_CLR 4'hC
`define CTF_BIT_LOW_CAP 0
`define CTF_BIT_SHUTDOWN 1
`define CTF_BIT_LOAD_MODEL 2
`define CTF_RST_CAP_WARN 16'h0000
`define CTF_RST_SD_SET 16'h0000
`define CTF_RST_SD_CLR 16'h0000
`define CTF_RST_LOAD_MODEL 1'h0
`define CTF_RESP_OKAY 2'h0
`define CTF_RESP_SLVERR 2'h2
`endif

// [hdl/ctf_compare.v]
// Purpose: threshold flag update logic
// Assumes: new values arrive with a one-cycle strobe
// Notes: combinational, registered by the parent
`timescale 1ns/1ps
module ctf_compare #(
	parameter W = 16
) (
	input wire cap_valid,
	input wire [W-1:0] cap,
	input wire volt_valid,
	input wire [W-1:0] volt,
	input wire [W-1:0] cap_warn,
	input wire [W-1:0] sd_set,
	input wire [W-1:0] sd_clr,
	input wire low_cap_cur,
	input wire sd_cur,
	output reg low_cap_next,
	output reg sd_next
);
	// hysteresis on the shutdown flag, one level for the low flag, equal value holds state
	always @* begin
		low_cap_next = low_cap_cur;
		sd_next = sd_cur;
		if (cap_valid) begin // see RULE8
			if (cap < cap_warn)
				low_cap_next = 1'b1; // see RULE1
			else if (cap > cap_warn)
				low_cap_next = 1'b0; // see RULE2
		end
		if (volt_valid) begin // see RULE8
			if (volt < sd_set)
				sd_next = 1'b1; // see RULE3
			else if (sd_cur && (volt > sd_clr))
				sd_next = 1'b0; // see RULE4
		end
	end
endmodule

// [tb/ctf_chk.sv]
// Purpose: port checker for the threshold flag block
// Assumes: one clock, synchronous active-low reset
// Notes: bound to ctf_top from the testbench top file
`timescale 1ns/1ps
module ctf_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic cap_valid,
	input wire logic volt_valid,
	input wire logic low_capacity_flag,
	input wire logic shutdown_warning_flag,
	input wire logic load_model_status_bit,
	input wire logic charge_level_int,
	input wire logic s_axi_bvalid
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// interrupt is high for exactly one cycle
	sequence s_pulse;
		charge_level_int ##1 !charge_level_int;
	endsequence
	AST_LC_SET: assert property ($rose(low_capacity_flag) |-> $past(cap_valid))
		else $error("low flag set with no sample");
	AST_LC_CLR: assert property ($fell(low_capacity_flag) |-> $past(cap_valid))
		else $error("low flag cleared with no sample");
	AST_SD_SET: assert property ($rose(shutdown_warning_flag) |-> $past(volt_valid))
		else $error("shutdown flag set with no sample");
	AST_SD_CLR: assert property ($fell(shutdown_warning_flag) |-> $past(volt_valid))
		else $error("shutdown flag cleared with no sample");
	AST_INT_PULSE: assert property ($changed(shutdown_warning_flag) |-> s_pulse)
		else $error("no interrupt pulse on flag change");
	AST_INT_CAUSE: assert property (!$changed(shutdown_warning_flag) |-> !charge_level_int)
		else $error("interrupt with no flag change");
	AST_LM_WRITE: assert property ($changed(load_model_status_bit) |-> $rose(s_axi_bvalid))
		else $error("load model bit moved without a write");
	AST_IDLE_HOLD: assert property (!cap_valid && !volt_valid |=> $stable(low_capacity_flag))
		else $error("low flag moved with no sample");
endmodule

// [tb/ctf_host.sv]
// Purpose: host side model counting interrupt pulses
// Assumes: interrupt is a one-cycle high pulse
// Notes: count cleared by reset
`timescale 1ns/1ps
module ctf_host (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic charge_level_int,
	output logic [15:0] int_count
);
	// count each pulse seen on the pin
	always @(posedge aclk) begin
		if (!aresetn)
			int_count <= 16'h0000;
		else if (charge_level_int)
			int_count <= int_count + 16'h0001;
	end
endmodule

// [tb/charge_threshold_flags_test.sv]
// Purpose: self-checking bench for ctf_top
// Assumes: AXI4-Lite master tasks, random samples with fixed seed
// Notes: expected flags come from a bench-side model
`timescale 1ns/1ps
`include "ctf_map.vh"
module charge_threshold_flags_test;
	logic aclk=0, aresetn=0, cap_valid=0, volt_valid=0, s_axi_awvalid=0, s_axi_wvalid=0;
	logic s_axi_bready=0, s_axi_arvalid=0, s_axi_rready=0, elc=0, esd=0, osd;
	logic [15:0] remaining_charge=0, cell_voltage=0, warn, sset, sclr;
	logic [3:0] s_axi_awaddr=0, s_axi_araddr=0, s_axi_wstrb=4'hF;
	logic [31:0] s_axi_wdata=0;
	wire low_capacity_flag, shutdown_warning_flag, load_model_status_bit, charge_level_int;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [15:0] n_int;
	int error_cnt=0, n_compared=0, n_exp=0, i;
	ctf_top dut (.*);
	ctf_host host (.aclk(aclk), .aresetn(aresetn), .charge_level_int(charge_level_int),
		.int_count(n_int));
	initial forever #5 aclk = ~aclk;
	////////////////////////////////////////////////////////////////
	task stop_test;
		if (error_cnt == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %0t got %h exp %h", $time, g, e);
		end
	endtask
	task hang;
		error_cnt++;
		$display("Error %0t timeout", $time);
		stop_test;
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er = `CTF_RESP_OKAY);
		bit dn;
		dn = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		for (int k = 0; k < 20 && !dn; k++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid) begin
				s_axi_bready <= 0;
				dn = 1;
				chk(s_axi_bresp, er);
			end
		end
		if (!dn) hang;
	endtask
	task rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		bit dn;
		dn = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		for (int k = 0; k < 20 && !dn; k++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid) begin
				s_axi_rready <= 0;
				dn = 1;
				chk(s_axi_rdata, ed);
				chk(s_axi_rresp, er);
			end
		end
		if (!dn) hang;
	endtask
	// one sample, then flag and interrupt checks against the model
	task smp(input bit c, input logic [15:0] v);
		@(posedge aclk);
		if (c) {cap_valid, remaining_charge} <= {1'b1, v};
		else {volt_valid, cell_voltage} <= {1'b1, v};
		@(posedge aclk);
		cap_valid <= 0;
		volt_valid <= 0;
		osd = esd;
		if (c) elc = v < warn ? 1 : v > warn ? 0 : elc;
		else esd = v < sset ? 1 : (esd && v > sclr) ? 0 : esd;
		n_exp += (esd != osd);
		#1 chk(low_capacity_flag, elc);
		chk(shutdown_warning_flag, esd);
		chk(charge_level_int, esd != osd);
		@(posedge aclk);
		#1 chk(charge_level_int, 0);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'hB9DA));
		warn = $urandom_range(16'hF000, 16'h0100);
		sset = $urandom_range(16'h0F00, 16'h0800);
		sclr = sset + 16'h0100;
		repeat (10) @(posedge aclk);
		aresetn <= 1;
		for (i = 0; i < 4; i++) rd(4 * i, 0, `CTF_RESP_OKAY);
		rd(4'h1, 0, `CTF_RESP_SLVERR);
		wr(4'h2, 32'h0000FFFF, `CTF_RESP_SLVERR);
		wr(`CTF_OFF_CAP_WARN, warn);
		wr(`CTF_OFF_SD_SET, sset);
		wr(`CTF_OFF_SD_CLR, sclr);
		rd(`CTF_OFF_SD_CLR, sclr, `CTF_RESP_OKAY);
		wr(`CTF_OFF_FLAGS, 32'h4);
		chk(load_model_status_bit, 1);
		rd(`CTF_OFF_FLAGS, 32'h4, `CTF_RESP_OKAY);
		wr(`CTF_OFF_FLAGS, 32'h3);
		chk(load_model_status_bit, 0);
		for (i = 0; i < 4; i++) smp(1, warn + i - 1);
		for (i = 0; i < 3; i++) smp(0, i == 0 ? sset - 1 : sclr + i - 1);
		repeat (200) smp($urandom % 2, $urandom);
		rd(`CTF_OFF_FLAGS, {esd, elc}, `CTF_RESP_OKAY);
		chk(n_int, n_exp);
		stop_test;
	end
	initial begin
		#100000;
		hang;
	end
endmodule
bind ctf_top ctf_chk chk (.*);
